// ===== logic/esc_pkg.sv
// Constants and types shared by the extended SMM memory control block
package esc_pkg;
   // Configuration byte holding the extended SMM memory control fields
   localparam logic [7:0] ESC_CTRL_OFS = 8'h9e;
   localparam logic [7:0] ESC_CTRL_RST = 8'h38;
   // Field positions inside the control byte
   localparam int ESC_HIGH_BIT = 7;
   localparam int ESC_ERR_BIT = 6;
   localparam int ESC_CACHE_BIT = 5;
   localparam int ESC_L1_BIT = 4;
   localparam int ESC_L2_BIT = 3;
   localparam int ESC_SIZE_HI = 2;
   localparam int ESC_SIZE_LO = 1;
   localparam int ESC_SEG_BIT = 0;
   // Reset values of the writable fields
   localparam logic ESC_HIGH_RST = 1'h0;
   localparam logic ESC_ERR_RST = 1'h0;
   localparam logic [1:0] ESC_SIZE_RST = 2'h0;
   localparam logic ESC_SEG_RST = 1'h0;
   localparam logic ESC_LOCK_RST = 1'h0;
   // Read-only cache report bits, always one
   localparam logic [2:0] ESC_CACHE_ONES = 3'h7;
   // Address widths: 36-bit host address, segment math in 1 MB units
   localparam int ESC_AW = 36;
   localparam int ESC_MBW = 12;
   localparam int ESC_MB_LSB = 20;
   localparam int ESC_WIN_LSB = 17;
   // High window and the legacy region it lands on (128 KB each)
   localparam logic [35:0] ESC_HIGH_BASE = 36'h0_feda_0000;
   localparam logic [35:0] ESC_LOW_BASE = 36'h0_000a_0000;
   // Segment size codes and their sizes in MB
   localparam logic [1:0] ESC_SZ_1M = 2'h0;
   localparam logic [1:0] ESC_SZ_2M = 2'h1;
   localparam logic [1:0] ESC_SZ_8M = 2'h2;
   localparam logic [11:0] ESC_MB_1 = 12'h001;
   localparam logic [11:0] ESC_MB_2 = 12'h002;
   localparam logic [11:0] ESC_MB_8 = 12'h008;
   localparam logic [11:0] ESC_MB_NONE = 12'h000;

   // Where a host request is sent
   typedef enum logic [1:0] {
      ESC_RT_NONE = 2'b00,
      ESC_RT_DRAM = 2'b01,
      ESC_RT_HUB = 2'b10
   } esc_route_e;

   // Segment size in MB for a size code; reserved code gives no segment
   function automatic logic [11:0] esc_seg_mb(input logic [1:0] code);
      case (code)
         ESC_SZ_1M: esc_seg_mb = ESC_MB_1;
         ESC_SZ_2M: esc_seg_mb = ESC_MB_2;
         ESC_SZ_8M: esc_seg_mb = ESC_MB_8;
         default: esc_seg_mb = ESC_MB_NONE;
      endcase
   endfunction : esc_seg_mb
endpackage : esc_pkg

// ===== logic/esc_ctl_if.sv
// Carrier between the control register and the address decoder
`timescale 1ns/1ps
interface esc_ctl_if;
   logic high_smram_enable;
   logic [1:0] protected_segment_size;
   logic protected_segment_enable_alias;
   logic err_set;

   modport regs (
      output high_smram_enable,
      output protected_segment_size,
      output protected_segment_enable_alias,
      input err_set
   );
   modport dec (
      input high_smram_enable,
      input protected_segment_size,
      input protected_segment_enable_alias,
      output err_set
   );
endinterface : esc_ctl_if

// ===== logic/esc_regs.sv
// Extended SMM memory control byte: storage, lock and error flag
`timescale 1ns/1ps
module esc_regs (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   input wire logic smm_lock,
   output logic [7:0] rdata,
   esc_ctl_if.regs ctl
);
   typedef struct packed {
      logic high;
      logic err;
      logic [1:0] size;
      logic seg;
   } esc_regs_s;

   esc_regs_s st_q;
   esc_regs_s st_d;

   ////////////////////////////////////////////////////////////////////////
   // Next state of the control fields
   always_comb begin
      st_d = st_q;
      if (wr_en && !smm_lock) begin
         st_d.high = wdata[esc_pkg::ESC_HIGH_BIT];
         st_d.size = wdata[esc_pkg::ESC_SIZE_HI:esc_pkg::ESC_SIZE_LO];
         st_d.seg = wdata[esc_pkg::ESC_SEG_BIT];
      end
      // Write one clears, zero leaves alone; a new error wins
      if (wr_en && wdata[esc_pkg::ESC_ERR_BIT]) begin
         st_d.err = 1'h0;
      end
      if (ctl.err_set) begin
         st_d.err = 1'h1;
      end
   end

   // Register the fields; reset gives the documented byte
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q.high <= esc_pkg::ESC_HIGH_RST;
         st_q.err <= esc_pkg::ESC_ERR_RST;
         st_q.size <= esc_pkg::ESC_SIZE_RST;
         st_q.seg <= esc_pkg::ESC_SEG_RST;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read view and fields handed to the decoder
   assign rdata = {st_q.high, st_q.err, esc_pkg::ESC_CACHE_ONES,
                   st_q.size, st_q.seg};
   assign ctl.high_smram_enable = st_q.high;
   assign ctl.protected_segment_size = st_q.size;
   assign ctl.protected_segment_enable_alias = st_q.seg;
endmodule : esc_regs

// ===== logic/esc_decode.sv
// Classifies a host request against the high window and the segment
`timescale 1ns/1ps
module esc_decode (
   input wire logic req_valid,
   input wire logic [35:0] req_addr,
   input wire logic req_smm,
   input wire logic global_smram_enable,
   input wire logic open_eff,
   input wire logic [11:0] seg_top_mb,
   output logic [1:0] route,
   output logic [35:0] out_addr,
   esc_ctl_if.dec ctl
);
   logic high_on;
   logic seg_on;
   logic high_hit;
   logic seg_hit;
   logic allowed;
   logic [11:0] seg_mb;
   logic [11:0] seg_base;
   logic [11:0] addr_mb;

   ////////////////////////////////////////////////////////////////////////
   // Effective enables, both gated by the global enable
   assign high_on = global_smram_enable && ctl.high_smram_enable;
   assign seg_on = global_smram_enable
                   && ctl.protected_segment_enable_alias;

   // Segment bounds in MB; reserved size or underflow gives no segment
   assign seg_mb = esc_pkg::esc_seg_mb(ctl.protected_segment_size);
   assign seg_base = seg_top_mb - seg_mb;
   assign addr_mb = req_addr[31:esc_pkg::ESC_MB_LSB];

   // Window hits
   assign high_hit = high_on && (req_addr[35:esc_pkg::ESC_WIN_LSB]
                     == esc_pkg::ESC_HIGH_BASE[35:esc_pkg::ESC_WIN_LSB]);
   assign seg_hit = seg_on && (req_addr[35:32] == 4'h0)
                    && (seg_mb != esc_pkg::ESC_MB_NONE)
                    && (seg_top_mb >= seg_mb)
                    && (addr_mb >= seg_base) && (addr_mb < seg_top_mb);

   // SMM requests or an open, unlocked space may reach DRAM
   assign allowed = req_smm || open_eff;

   ////////////////////////////////////////////////////////////////////////
   // Route, remapped address and error event
   always_comb begin
      route = esc_pkg::ESC_RT_NONE;
      out_addr = req_addr;
      ctl.err_set = 1'h0;
      if (req_valid && high_hit) begin
         if (allowed) begin
            route = esc_pkg::ESC_RT_DRAM;
            out_addr = esc_pkg::ESC_LOW_BASE
                       | {19'h0, req_addr[16:0]};
         end else begin
            route = esc_pkg::ESC_RT_HUB;
            ctl.err_set = 1'h1;
         end
      end else if (req_valid && seg_hit) begin
         if (allowed) begin
            route = esc_pkg::ESC_RT_DRAM;
         end else begin
            route = esc_pkg::ESC_RT_HUB;
            ctl.err_set = 1'h1;
         end
      end
   end
endmodule : esc_decode

// ===== logic/esc_top.sv
// Extended SMM memory control: config byte, lock and request decode
//
// How it works
// - High SMRAM is on only when the global enable and bit 7 are both one.
// - On, the high window is redirected to A0000h..BFFFFh at equal offset for SMM requests or while open and unlocked.
// - A non-SMM touch of either range with space closed sets bit 6.
// - Bit 6 clears only on reset or when software writes a one to it.
// - Bits 5, 4 and 3 are read-only and always read as one.
// - Size code 00, 01, 10 gives a 1, 2 or 8 MB segment; 11 is reserved.
// - Segment top is DRAM top less both stolen sizes; base is top less size.
// - The segment reaches DRAM for requests that carry the SMM mark, or for any request while open and unlocked.
// - With the segment on, non-SMM accesses to it go to the downstream hub unless the space is open and unlocked.
// - The segment exists only when the global enable and bit 0 are both one.
// - Once locked, bits 7, 2:1 and 0 ignore writes.
// - The byte at 9Eh resets to 38h.
// - The lock is set by a write, cleared only by reset, and blocks open.
// - All extended functions need the global enable to be one.
// - Open and unlocked makes SMM DRAM visible to non-SMM accesses.
`timescale 1ns/1ps
module esc_top (
   input wire logic ref_clk,
   input wire logic rst,
   // Configuration byte port
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   output logic cfg_rd_valid,
   output logic cfg_hit,
   // Loose control bits owned by the neighbouring SMM control byte
   input wire logic global_smram_enable,
   input wire logic space_open,
   input wire logic smm_lock_set,
   output logic smm_lock,
   output logic space_open_eff,
   // Memory map inputs in 1 MB units
   input wire logic [11:0] top_of_low_usable_dram,
   input wire logic [11:0] graphics_translation_table_mb,
   input wire logic [11:0] graphics_stolen_mb,
   // Host request
   input wire logic req_valid,
   input wire logic [35:0] req_addr,
   input wire logic req_smm,
   // Decoded result, one cycle later
   output logic rsp_valid,
   output logic rsp_to_dram,
   output logic rsp_to_hub,
   output logic [35:0] rsp_addr
);
   typedef struct packed {
      logic lock;
      logic [7:0] rdata;
      logic rd_valid;
      logic hit;
      logic open_eff;
      logic [11:0] seg_top;
      logic rsp_valid;
      logic to_dram;
      logic to_hub;
      logic [35:0] rsp_addr;
   } esc_top_s;

   esc_top_s st_q;
   esc_top_s st_d;

   esc_ctl_if ctl ();

   logic sel;
   logic byte_wr;
   logic [7:0] reg_rdata;
   logic [1:0] route;
   logic [35:0] dec_addr;
   logic open_now;

   ////////////////////////////////////////////////////////////////////////
   // Address decode of the configuration port
   assign sel = (cfg_addr == esc_pkg::ESC_CTRL_OFS);
   assign byte_wr = cfg_wr && sel;

   // Open only counts while unlocked
   assign open_now = space_open && !st_q.lock;

   ////////////////////////////////////////////////////////////////////////
   // Control byte storage
   esc_regs u_regs (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(byte_wr),
      .wdata(cfg_wdata),
      .smm_lock(st_q.lock),
      .rdata(reg_rdata),
      .ctl(ctl.regs)
   );

   // Request classification
   esc_decode u_dec (
      .req_valid(req_valid),
      .req_addr(req_addr),
      .req_smm(req_smm),
      .global_smram_enable(global_smram_enable),
      .open_eff(open_now),
      .seg_top_mb(st_q.seg_top),
      .route(route),
      .out_addr(dec_addr),
      .ctl(ctl.dec)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state: lock, read data, segment top and registered answer
   always_comb begin
      st_d = st_q;
      // Lock is sticky until reset
      if (smm_lock_set) begin
         st_d.lock = 1'h1;
      end
      st_d.open_eff = space_open && !st_d.lock;
      // Segment top, held in a flop to keep the subtract off the request path
      st_d.seg_top = top_of_low_usable_dram
                     - graphics_translation_table_mb
                     - graphics_stolen_mb;
      // Reads of other offsets return zero and no hit
      st_d.rd_valid = cfg_rd;
      st_d.hit = (cfg_rd || cfg_wr) && sel;
      st_d.rdata = (cfg_rd && sel) ? reg_rdata : 8'h00;
      // Answer for the request seen this cycle
      st_d.rsp_valid = req_valid;
      st_d.to_dram = (route == esc_pkg::ESC_RT_DRAM);
      st_d.to_hub = (route == esc_pkg::ESC_RT_HUB);
      st_d.rsp_addr = dec_addr;
   end

   // Registers; reset leaves the lock clear and no answer pending
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q.lock <= esc_pkg::ESC_LOCK_RST;
         st_q.rdata <= 8'h00;
         st_q.rd_valid <= 1'h0;
         st_q.hit <= 1'h0;
         st_q.open_eff <= 1'h0;
         st_q.seg_top <= 12'h000;
         st_q.rsp_valid <= 1'h0;
         st_q.to_dram <= 1'h0;
         st_q.to_hub <= 1'h0;
         st_q.rsp_addr <= 36'h0_0000_0000;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from flops
   assign cfg_rdata = st_q.rdata;
   assign cfg_rd_valid = st_q.rd_valid;
   assign cfg_hit = st_q.hit;
   assign smm_lock = st_q.lock;
   assign space_open_eff = st_q.open_eff;
   assign rsp_valid = st_q.rsp_valid;
   assign rsp_to_dram = st_q.to_dram;
   assign rsp_to_hub = st_q.to_hub;
   assign rsp_addr = st_q.rsp_addr;
endmodule : esc_top

// ===== tb/esc_chk.sv
// Assertion checker for the extended SMM memory control block
`timescale 1ns/1ps
module esc_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_rdata,
   input wire logic cfg_rd_valid,
   input wire logic cfg_hit,
   input wire logic global_smram_enable,
   input wire logic space_open,
   input wire logic smm_lock_set,
   input wire logic smm_lock,
   input wire logic space_open_eff,
   input wire logic req_valid,
   input wire logic [35:0] req_addr,
   input wire logic req_smm,
   input wire logic rsp_valid,
   input wire logic rsp_to_dram,
   input wire logic rsp_to_hub,
   input wire logic [35:0] rsp_addr
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   // Request answers and routing
   a_rsp_one_cycle: assert property (
      req_valid |=> rsp_valid) else $error("no response after request");
   a_high_remap: assert property (
      req_valid && req_addr[35:17] == esc_pkg::ESC_HIGH_BASE[35:17] |=>
      !rsp_to_dram || rsp_addr == {esc_pkg::ESC_LOW_BASE[35:17],
      $past(req_addr[16:0])}) else $error("high window remap wrong");
   a_global_gate: assert property (
      req_valid && !global_smram_enable |=> !rsp_to_dram && !rsp_to_hub)
      else $error("claimed with global enable off");
   a_smm_no_hub: assert property (
      req_valid && req_smm |=> !rsp_to_hub) else $error("SMM sent to hub");
   a_open_no_hub: assert property (
      req_valid && space_open && !smm_lock && !smm_lock_set |=> !rsp_to_hub)
      else $error("open access sent to hub");
   a_route_one: assert property (
      !(rsp_to_dram && rsp_to_hub)) else $error("two routes at once");
   ////////////////////////////////////////////////////////////////////////
   // Lock, open and register reads
   a_lock_sets: assert property (
      smm_lock_set |=> smm_lock[*3]) else $error("lock not set or lost");
   a_lock_closes: assert property (
      smm_lock_set || smm_lock |=> !space_open_eff)
      else $error("open while locked");
   a_cache_ones: assert property (
      cfg_rd |=> cfg_rd_valid && (!cfg_hit || cfg_rdata[5:3] == 3'h7))
      else $error("cache bits not one");
   // Main scenarios
   c_dram: cover property (rsp_valid && rsp_to_dram);
   c_hub: cover property (rsp_valid && rsp_to_hub);
   c_lock: cover property (smm_lock_set);
endmodule : esc_chk
bind esc_top esc_chk chk_u (.ref_clk(ref_clk), .rst(rst),
   .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
   .cfg_hit(cfg_hit), .global_smram_enable(global_smram_enable),
   .space_open(space_open), .smm_lock_set(smm_lock_set),
   .smm_lock(smm_lock), .space_open_eff(space_open_eff),
   .req_valid(req_valid), .req_addr(req_addr), .req_smm(req_smm),
   .rsp_valid(rsp_valid), .rsp_to_dram(rsp_to_dram),
   .rsp_to_hub(rsp_to_hub), .rsp_addr(rsp_addr));

// ===== tb/esc_host_model.sv
// Host processor model issuing memory requests with or without the SMM mark
`timescale 1ns/1ps
module esc_host_model (
   input wire logic ref_clk,
   input wire logic go,
   input wire logic [35:0] go_addr,
   input wire logic go_smm,
   output logic req_valid,
   output logic [35:0] req_addr,
   output logic req_smm
);
   // Idle bus at time zero
   initial begin
      req_valid = 1'b0;
      req_addr = 36'h0;
      req_smm = 1'b0;
   end
   // One-cycle request off the falling edge; idle lines do not hold
   always @(negedge ref_clk) begin
      req_valid <= go;
      req_addr <= go ? go_addr : ~req_addr;
      req_smm <= go ? go_smm : ~req_smm;
   end
endmodule : esc_host_model

// ===== tb/extended_smram_control_tb.sv
// Self-checking bench for the extended SMM memory control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
 fail_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module extended_smram_control_tb;
   typedef struct packed {
      logic [35:0] a;
      logic smm;
      logic [1:0] rt;
      logic [35:0] ra;
   } esc_row_s;
   logic ref_clk, rst, cfg_wr, cfg_rd, cfg_rd_valid, cfg_hit;
   logic global_smram_enable, space_open, smm_lock_set, smm_lock;
   logic space_open_eff, req_valid, req_smm, rsp_valid;
   logic rsp_to_dram, rsp_to_hub, go, go_smm;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
   logic [11:0] top_of_low_usable_dram, graphics_translation_table_mb;
   logic [11:0] graphics_stolen_mb, base;
   logic [35:0] req_addr, rsp_addr, go_addr;
   logic [11:0] mb [3] = '{12'h001, 12'h002, 12'h008};
   int fail_count, n_checks;
   // Segment of 8 MB below top 3F7h: base 3EFh
   esc_row_s rows [9] = '{
      '{36'h0_feda_1234, 1'b1, 2'h1, 36'h0_000a_1234},
      '{36'h0_fedb_ffff, 1'b1, 2'h1, 36'h0_000b_ffff},
      '{36'h0_fedc_0000, 1'b1, 2'h0, 36'h0},
      '{36'h0_3ef0_0000, 1'b1, 2'h1, 36'h0_3ef0_0000},
      '{36'h0_3f6f_ffff, 1'b1, 2'h1, 36'h0_3f6f_ffff},
      '{36'h0_3f70_0000, 1'b1, 2'h0, 36'h0},
      '{36'h0_3eef_ffff, 1'b1, 2'h0, 36'h0},
      '{36'h0_3ef0_0000, 1'b0, 2'h2, 36'h0},
      '{36'h0_feda_0000, 1'b0, 2'h2, 36'h0}};
   esc_top dut_u (.ref_clk(ref_clk), .rst(rst), .cfg_addr(cfg_addr),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid), .cfg_hit(cfg_hit),
      .global_smram_enable(global_smram_enable), .space_open(space_open),
      .smm_lock_set(smm_lock_set), .smm_lock(smm_lock),
      .space_open_eff(space_open_eff),
      .top_of_low_usable_dram(top_of_low_usable_dram),
      .graphics_translation_table_mb(graphics_translation_table_mb),
      .graphics_stolen_mb(graphics_stolen_mb), .req_valid(req_valid),
      .req_addr(req_addr), .req_smm(req_smm), .rsp_valid(rsp_valid),
      .rsp_to_dram(rsp_to_dram), .rsp_to_hub(rsp_to_hub),
      .rsp_addr(rsp_addr));
   esc_host_model host_u (.ref_clk, .go, .go_addr, .go_smm, .req_valid,
      .req_addr, .req_smm);
   ////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      #20000;
      fail_count++;
      complete_run();
   end
   ////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic complete_run();
      if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   // Configuration write of the control byte
   task automatic cfg_write(input logic [7:0] d);
      @(negedge ref_clk);
      cfg_wr = 1'b1;
      cfg_addr = 8'h9e;
      cfg_wdata = d;
      @(negedge ref_clk);
      cfg_wr = 1'b0;
   endtask : cfg_write
   // Configuration read, answer one cycle later
   task automatic cfg_read(input logic [7:0] ofs, input logic [7:0] e);
      @(negedge ref_clk);
      cfg_rd = 1'b1;
      cfg_addr = ofs;
      @(negedge ref_clk);
      cfg_rd = 1'b0;
      `CHK("rd_valid", 1'b1, cfg_rd_valid)
      `CHK("cfg_rdata", e, cfg_rdata)
      `CHK("cfg_hit", ofs == 8'h9e, cfg_hit)
   endtask : cfg_read
   // One host request through the model, route checked next cycle
   task automatic send(input logic [35:0] a, input logic s,
      input logic [1:0] rt, input logic [35:0] ra);
      @(negedge ref_clk);
      go <= 1'b1;
      go_addr <= a;
      go_smm <= s;
      @(negedge ref_clk);
      go <= 1'b0;
      @(negedge ref_clk);
      `CHK("rsp_valid", 1'b1, rsp_valid)
      `CHK("route", rt, {rsp_to_hub, rsp_to_dram})
      if (rt == 2'h1) `CHK("rsp_addr", ra, rsp_addr)
   endtask : send
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {cfg_wr, cfg_rd, smm_lock_set, space_open, go, go_smm} = 6'h0;
      cfg_addr = 8'h0;
      cfg_wdata = 8'h0;
      go_addr = 36'h0;
      global_smram_enable = 1'b0;
      top_of_low_usable_dram = 12'h400;
      graphics_translation_table_mb = 12'h001;
      graphics_stolen_mb = 12'h008;
      rst = 1'b1;
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      cfg_read(8'h9e, 8'h38);
      cfg_read(8'h9d, 8'h00);
      global_smram_enable = 1'b1;
      cfg_write(8'h85);
      foreach (rows[i]) send(rows[i].a, rows[i].smm, rows[i].rt, rows[i].ra);
      cfg_read(8'h9e, 8'hfd);
      cfg_write(8'h85);
      cfg_read(8'h9e, 8'hfd);
      cfg_write(8'hc5);
      cfg_read(8'h9e, 8'hbd);
      // Each valid size code 00, 01 and 10, first and last-below base address
      for (int c = 0; c < 3; c++) begin
         cfg_write({2'h2, 3'h0, c[1:0], 1'b1});
         base = 12'h3f7 - mb[c];
         send({4'h0, base, 20'h0}, 1'b1, 2'h1, {4'h0, base, 20'h0});
         send({4'h0, base - 12'h1, 20'hfffff}, 1'b1, 2'h0, 36'h0);
      end
      cfg_write(8'h87);
      send(36'h0_3f60_0000, 1'b1, 2'h0, 36'h0);
      cfg_write(8'h84);
      send(36'h0_3f60_0000, 1'b1, 2'h0, 36'h0);
      cfg_write(8'h05);
      send(36'h0_feda_0000, 1'b1, 2'h0, 36'h0);
      cfg_write(8'h85);
      global_smram_enable = 1'b0;
      send(36'h0_3f60_0000, 1'b1, 2'h0, 36'h0);
      global_smram_enable = 1'b1;
      space_open = 1'b1;
      send(36'h0_3f60_0000, 1'b0, 2'h1, 36'h0_3f60_0000);
      cfg_read(8'h9e, 8'hbd);
      // Lock: fields frozen, open forced off, sticky until reset
      @(negedge ref_clk);
      smm_lock_set = 1'b1;
      @(negedge ref_clk);
      smm_lock_set = 1'b0;
      `CHK("smm_lock", 1'b1, smm_lock)
      `CHK("open_eff", 1'b0, space_open_eff)
      cfg_write(8'h00);
      cfg_read(8'h9e, 8'hbd);
      send(36'h0_3f60_0000, 1'b0, 2'h2, 36'h0);
      // Clear while locked, then error and clear on one edge: error wins
      cfg_write(8'h40);
      cfg_read(8'h9e, 8'hbd);
      fork
         send(36'h0_3f60_0000, 1'b0, 2'h2, 36'h0);
         begin
            @(negedge ref_clk);
            cfg_write(8'h40);
         end
      join
      cfg_read(8'h9e, 8'hfd);
      `CHK("smm_lock", 1'b1, smm_lock)
      rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      `CHK("smm_lock", 1'b0, smm_lock)
      cfg_read(8'h9e, 8'h38);
      complete_run();
   end
endmodule : extended_smram_control_tb
